// ==== hw/analog_ref_combiner.sv ====
// Combines the analog option card channels into one frequency reference.
// Inputs are already synchronised; output is combinational, registered by the caller.
`timescale 1ns/1ps
module analog_ref_combiner #(
    parameter int ADC_W = 15
) (
    // Channel samples, sign and magnitude bits as two's complement
    input wire logic signed [ADC_W-1:0] ch1,
    input wire logic signed [ADC_W-1:0] ch2,
    input wire logic signed [ADC_W-1:0] ch3,
    // Card configuration
    input wire logic card_three,
    input wire logic combine,
    // Result
    output logic signed [ADC_W-1:0] reference
);
    localparam logic signed [ADC_W+1:0] MAXV = (ADC_W+2)'(2 ** (ADC_W - 1) - 1);
    localparam logic signed [ADC_W+1:0] MINV = -MAXV - (ADC_W+2)'(1);

    logic signed [ADC_W+1:0] sum;

    always_comb begin
        if (!card_three) begin
            // Two-channel card: voltage plus current, no selection needed
            sum = (ADC_W+2)'(ch1) + (ADC_W+2)'(ch2);
        end else if (combine) begin
            sum = (ADC_W+2)'(ch1) + (ADC_W+2)'(ch2) + (ADC_W+2)'(ch3);
        end else begin
            // Independent channels: channel 1 is the reference, the rest pass aside
            sum = (ADC_W+2)'(ch1);
        end
        // Saturate rather than wrap so an overrange sum never flips direction
        if (sum > MAXV) begin
            reference = MAXV[ADC_W-1:0];
        end else if (sum < MINV) begin
            reference = MINV[ADC_W-1:0];
        end else begin
            reference = sum[ADC_W-1:0];
        end
    end
endmodule

// ==== hw/fault_status_output_mapper.sv ====
// Fault and run-status mapper for an eight-terminal digital output card, plus
// configuration and combining of the analog reference card. APB3 register slave.
// Assumes fault, status and ADC inputs arrive asynchronously from the drive core.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "fault_map_params.svh"
module fault_status_output_mapper #(
    parameter int ADDR_W = 12,
    parameter int ADC_W = 15,
    parameter int FUNC_N = 38
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fault conditions from the drive
    input wire logic overcurrent_fault,
    input wire logic overvoltage_fault,
    input wire logic drive_overload_fault,
    input wire logic fuse_blown_fault,
    input wire logic overspeed_fault,
    input wire logic heatsink_overheat_fault,
    input wire logic motor_overload_fault,
    input wire logic braking_resistor_fault,
    input wire logic brake_transistor_fault,
    input wire logic external_fault,
    input wire logic controller_fault,
    input wire logic undervoltage_fault,
    input wire logic speed_deviation_fault,
    input wire logic encoder_open_fault,
    // Run status from the drive
    input wire logic zero_speed,
    input wire logic speed_agree,
    input wire logic drive_running,
    input wire logic minor_fault,
    // Multi-function output sources for per-channel selection
    input wire logic [FUNC_N-1:0] function_in,
    // Analog option card samples
    input wire logic [ADC_W-1:0] adc_ch1,
    input wire logic [ADC_W-1:0] adc_ch2,
    input wire logic [ADC_W-1:0] adc_ch3,
    // Output terminals, bit 0 = fault_out_a ... bit 5, bit 6 and bit 7 = the two relay pairs
    output logic [7:0] terminal_out,
    // Analog reference result
    output logic [ADC_W-1:0] frequency_ref,
    output logic frequency_ref_valid,
    // Interrupt
    output logic irq
);
    import fault_map_pkg::*;

    localparam int FN = int'(FI_COUNT);
    localparam int SEL_W = 6;
    localparam logic [31:0] CTRL_RST = `FM_CTRL_RST;

    typedef struct packed {
        logic [FN-1:0] fs1;
        logic [FN-1:0] fs2;
        logic [FUNC_N-1:0] mf1;
        logic [FUNC_N-1:0] mf2;
        logic [3*ADC_W-1:0] as1;
        logic [3*ADC_W-1:0] as2;
        out_mode_e mode;
        logic combine;
        logic card_three;
        logic [1:0] ref_src;
        logic [63:0] chsel;
        fault_code_e code;
        logic [7:0] term;
        logic [2:0] ist;
        logic [2:0] mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [ADC_W-1:0] aref;
        logic aref_valid;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic [FN-1:0] raw_in;
    logic [7:0] sel_bit;
    logic signed [ADC_W-1:0] comb_ref;

    assign raw_in = {minor_fault, drive_running, speed_agree, zero_speed,
                     encoder_open_fault, speed_deviation_fault, undervoltage_fault,
                     controller_fault, external_fault, brake_transistor_fault,
                     braking_resistor_fault, motor_overload_fault,
                     heatsink_overheat_fault, overspeed_fault, fuse_blown_fault,
                     drive_overload_fault, overvoltage_fault, overcurrent_fault};

    // Per-channel function pick; out-of-range selections drive the terminal off
    for (genvar i = 0; i < 8; i++) begin : g_chan
        logic [SEL_W-1:0] sel;
        assign sel = s_q.chsel[i*8 +: SEL_W];
        assign sel_bit[i] = (int'(sel) < FUNC_N) ? s_q.mf2[sel] : 1'b0;
    end

    analog_ref_combiner #(
        .ADC_W(ADC_W)
    ) u_combiner (
        .ch1(s_q.as2[0 +: ADC_W]),
        .ch2(s_q.as2[ADC_W +: ADC_W]),
        .ch3(s_q.as2[2*ADC_W +: ADC_W]),
        .card_three(s_q.card_three),
        .combine(s_q.combine),
        .reference(comb_ref)
    );

    // Lowest code wins when several faults are active
    function automatic fault_code_e encode(input logic [FN-1:0] f);
        fault_code_e c;
        c = FC_NONE;
        if (f[FI_OC]) c = FC_OVERCURRENT;
        else if (f[FI_VOLT]) c = FC_OVERVOLTAGE;
        else if (f[FI_DOL]) c = FC_DRIVE_OVERLOAD;
        else if (f[FI_OH]) c = FC_OVERHEAT;
        else if (f[FI_SPD]) c = FC_OVERSPEED;
        else if (f[FI_FUSE]) c = FC_FUSE;
        else if (f[FI_BRR] || f[FI_BRT]) c = FC_BRAKING;
        else if (f[FI_EXT]) c = FC_EXTERNAL;
        else if (f[FI_CTRL]) c = FC_CONTROLLER;
        else if (f[FI_MOL]) c = FC_MOTOR_OVERLOAD;
        else if (f[FI_UV]) c = FC_POWER_LOSS;
        else if (f[FI_DEVIATE]) c = FC_SPEED_DEVIATION;
        else if (f[FI_ENC]) c = FC_ENCODER_OPEN;
        return c;
    endfunction

    function automatic logic still_active(input fault_code_e c, input logic [FN-1:0] f);
        logic a;
        case (c)
            FC_OVERCURRENT: a = f[FI_OC];
            FC_OVERVOLTAGE: a = f[FI_VOLT];
            FC_DRIVE_OVERLOAD: a = f[FI_DOL];
            FC_OVERHEAT: a = f[FI_OH];
            FC_OVERSPEED: a = f[FI_SPD];
            FC_FUSE: a = f[FI_FUSE];
            FC_BRAKING: a = f[FI_BRR] | f[FI_BRT];
            FC_EXTERNAL: a = f[FI_EXT];
            FC_CONTROLLER: a = f[FI_CTRL];
            FC_MOTOR_OVERLOAD: a = f[FI_MOL];
            FC_POWER_LOSS: a = f[FI_UV];
            FC_SPEED_DEVIATION: a = f[FI_DEVIATE];
            FC_ENCODER_OPEN: a = f[FI_ENC];
            default: a = 1'b0;
        endcase
        return a;
    endfunction

    always_comb begin
        logic [FN-1:0] f;
        logic [2:0] ev;
        logic [2:0] clr;
        logic access;
        logic hit;
        logic bad;
        logic [31:0] rd;
        f = '0;
        ev = '0;
        clr = '0;
        access = 1'b0;
        hit = 1'b0;
        bad = 1'b0;
        rd = '0;
        s_d = s_q;

        // Two-stage synchronisers for everything from the drive core
        s_d.fs1 = raw_in;
        s_d.fs2 = s_q.fs1;
        s_d.mf1 = function_in;
        s_d.mf2 = s_q.mf1;
        s_d.as1 = {adc_ch3, adc_ch2, adc_ch1};
        s_d.as2 = s_q.as1;
        f = s_q.fs2;

        // Held code only yields once its own fault has gone
        if (s_q.code == FC_NONE || !still_active(s_q.code, f)) begin
            s_d.code = encode(f);
        end
        ev[`FM_EV_FAULT_SET] = (s_q.code == FC_NONE) && (s_d.code != FC_NONE);
        ev[`FM_EV_FAULT_CLR] = (s_q.code != FC_NONE) && (s_d.code == FC_NONE);

        case (s_q.mode)
            MODE_SEPARATE: begin
                s_d.term = {f[FI_AGREE], f[FI_ZERO], f[FI_OH] | f[FI_MOL], f[FI_SPD],
                            f[FI_FUSE], f[FI_DOL], f[FI_VOLT], f[FI_OC]};
            end
            MODE_BINARY: begin
                // Next code, so code bits and status bits leave on the same edge
                s_d.term = {f[FI_MINOR], f[FI_RUN], f[FI_AGREE], f[FI_ZERO],
                            s_d.code};
            end
            MODE_SELECT: begin
                s_d.term = sel_bit;
            end
            default: begin
                s_d.term = '0;
            end
        endcase

        // Option card reference is honoured under the option source setting, or under the terminal source on a three-channel card with independent channels
        s_d.aref = comb_ref;
        s_d.aref_valid = (s_q.ref_src == `FM_REFSRC_OPTION)
            || (s_q.card_three && !s_q.combine
                && s_q.ref_src == `FM_REFSRC_TERMINALS);

        // APB: one wait state, answer decided in the first access cycle
        access = psel && penable;
        if (access && !s_q.pready) begin
            hit = 1'b1;
            case (paddr)
                `FM_OFF_CTRL: begin
                    rd[`FM_CTRL_MODE_LSB +: 2] = s_q.mode;
                    rd[`FM_CTRL_COMBINE_BIT] = s_q.combine;
                    rd[`FM_CTRL_CARD3_BIT] = s_q.card_three;
                    rd[`FM_CTRL_REFSRC_LSB +: 2] = s_q.ref_src;
                    // Mode locked while running and limited to the three modes
                    bad = pwrite && (f[FI_RUN]
                        || pwdata[`FM_CTRL_MODE_LSB +: 2] > MODE_SELECT);
                end
                `FM_OFF_CHSEL_LO: begin
                    rd = s_q.chsel[31:0];
                    for (int k = 0; k < 4; k++) begin
                        if (pwrite && (pwdata[k*8 +: 8] > 8'(`FM_SEL_MAX) || f[FI_RUN])) begin
                            bad = 1'b1;
                        end
                    end
                end
                `FM_OFF_CHSEL_HI: begin
                    rd = s_q.chsel[63:32];
                    for (int k = 0; k < 4; k++) begin
                        if (pwrite && (pwdata[k*8 +: 8] > 8'(`FM_SEL_MAX) || f[FI_RUN])) begin
                            bad = 1'b1;
                        end
                    end
                end
                `FM_OFF_STATUS: begin
                    rd[7:0] = s_q.term;
                    rd[`FM_ST_CODE_LSB +: 4] = s_q.code;
                    rd[`FM_ST_RUN_BIT] = f[FI_RUN];
                    rd[`FM_ST_VALID_BIT] = s_q.aref_valid;
                end
                `FM_OFF_INT_STAT: rd[2:0] = s_q.ist;
                `FM_OFF_INT_MASK: rd[2:0] = s_q.mask;
                `FM_OFF_ANA_REF: rd = 32'(signed'(s_q.aref));
                `FM_OFF_ANA_AUX: begin
                    rd[ADC_W-1:0] = s_q.as2[ADC_W +: ADC_W];
                    rd[16 +: ADC_W] = s_q.as2[2*ADC_W +: ADC_W];
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
            s_d.pready = 1'b1;
            s_d.pslverr = !hit || bad;
            s_d.prdata = pwrite ? 32'h0000_0000 : rd;
            ev[`FM_EV_REFUSED] = bad;
        end else if (access) begin
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
            if (pwrite && !s_q.pslverr) begin
                case (paddr)
                    `FM_OFF_CTRL: begin
                        s_d.mode = out_mode_e'(pwdata[`FM_CTRL_MODE_LSB +: 2]);
                        s_d.combine = pwdata[`FM_CTRL_COMBINE_BIT];
                        s_d.card_three = pwdata[`FM_CTRL_CARD3_BIT];
                        s_d.ref_src = pwdata[`FM_CTRL_REFSRC_LSB +: 2];
                    end
                    `FM_OFF_CHSEL_LO: s_d.chsel[31:0] = pwdata;
                    `FM_OFF_CHSEL_HI: s_d.chsel[63:32] = pwdata;
                    `FM_OFF_INT_STAT: clr = pwdata[2:0];
                    `FM_OFF_INT_MASK: s_d.mask = pwdata[2:0];
                    default: begin
                    end
                endcase
            end
        end else begin
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
        end

        // New events beat a simultaneous write-one-to-clear
        s_d.ist = (s_q.ist & ~clr) | ev;
        s_d.irq = |(s_d.ist & s_q.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.mode <= MODE_SEPARATE;
            s_q.combine <= CTRL_RST[`FM_CTRL_COMBINE_BIT];
            s_q.card_three <= CTRL_RST[`FM_CTRL_CARD3_BIT];
            s_q.chsel <= {`FM_CHSEL_HI_RST, `FM_CHSEL_LO_RST};
            s_q.code <= FC_NONE;
            s_q.mask <= `FM_MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign terminal_out = s_q.term;
    assign frequency_ref = s_q.aref;
    assign frequency_ref_valid = s_q.aref_valid;
    assign irq = s_q.irq;
endmodule

// ==== shared/fault_map_params.svh ====
// Register map, field positions and reset values of the fault/status output mapper.
// Included by the mapper package users; holds definitions only.
`ifndef FAULT_MAP_PARAMS_SVH
`define FAULT_MAP_PARAMS_SVH

`define FM_OFF_CTRL 12'h000
`define FM_OFF_CHSEL_LO 12'h004
`define FM_OFF_CHSEL_HI 12'h008
`define FM_OFF_STATUS 12'h00C
`define FM_OFF_INT_STAT 12'h010
`define FM_OFF_INT_MASK 12'h014
`define FM_OFF_ANA_REF 12'h018
`define FM_OFF_ANA_AUX 12'h01C

`define FM_CTRL_MODE_LSB 0
`define FM_CTRL_COMBINE_BIT 2
`define FM_CTRL_CARD3_BIT 3
`define FM_CTRL_REFSRC_LSB 4

`define FM_ST_CODE_LSB 8
`define FM_ST_RUN_BIT 12
`define FM_ST_VALID_BIT 13

`define FM_EV_FAULT_SET 0
`define FM_EV_FAULT_CLR 1
`define FM_EV_REFUSED 2

`define FM_CTRL_RST 32'h0000_0008
`define FM_CHSEL_LO_RST 32'h0402_0100
`define FM_CHSEL_HI_RST 32'h0F0F_2506
`define FM_MASK_RST 3'h0

`define FM_SEL_MAX 6'h25
`define FM_REFSRC_TERMINALS 2'h1
`define FM_REFSRC_OPTION 2'h3

`endif

// ==== shared/fault_map_pkg.sv ====
// Types shared by the fault/status output mapper and its bench.
package fault_map_pkg;

    typedef enum logic [1:0] {
        MODE_SEPARATE = 2'b00,
        MODE_BINARY = 2'b01,
        MODE_SELECT = 2'b10
    } out_mode_e;

    typedef enum logic [3:0] {
        FC_NONE = 4'b0000,
        FC_OVERCURRENT = 4'b0001,
        FC_OVERVOLTAGE = 4'b0010,
        FC_DRIVE_OVERLOAD = 4'b0011,
        FC_OVERHEAT = 4'b0100,
        FC_OVERSPEED = 4'b0101,
        FC_FUSE = 4'b0110,
        FC_BRAKING = 4'b0111,
        FC_EXTERNAL = 4'b1000,
        FC_CONTROLLER = 4'b1001,
        FC_MOTOR_OVERLOAD = 4'b1010,
        FC_POWER_LOSS = 4'b1100,
        FC_SPEED_DEVIATION = 4'b1101,
        FC_ENCODER_OPEN = 4'b1110
    } fault_code_e;

    // Bit positions in the synchronised input vector
    typedef enum int {
        FI_OC, FI_VOLT, FI_DOL, FI_FUSE, FI_SPD, FI_OH, FI_MOL, FI_BRR, FI_BRT,
        FI_EXT, FI_CTRL, FI_UV, FI_DEVIATE, FI_ENC, FI_ZERO, FI_AGREE, FI_RUN, FI_MINOR,
        FI_COUNT
    } fault_idx_e;

endpackage

// ==== sim/fault_map_properties.sv ====
// Concurrent checks on the ports of the fault/status output mapper.
// Bound to the mapper top; inputs reach the terminals three edges after they change.
`timescale 1ns/1ps
module fault_map_properties #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Drive side
    input wire logic overcurrent_fault,
    input wire logic zero_speed,
    input wire logic speed_agree,
    input wire logic drive_running,
    input wire logic minor_fault,
    input wire logic [7:0] terminal_out
);
    logic [1:0] mode_q;
    logic [2:0] age_q;
    logic done;
    logic ctrl_wr;
    logic settled;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    assign done = psel && penable && pready;
    assign ctrl_wr = done && pwrite && paddr == '0;
    assign settled = age_q >= 3'h4;

    // Mirror of the committed mode; terminal checks wait until the pipeline has refilled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 2'h0;
            age_q <= 3'h0;
        end else if (ctrl_wr && !pslverr) begin
            mode_q <= pwdata[1:0];
            age_q <= 3'h0;
        end else if (!settled) begin
            age_q <= age_q + 3'h1;
        end
    end

    single_ready_a: assert property (pready |=> !pready)
        else $error("pready held for more than one cycle");
    wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered after one wait state");
    mode_range_a: assert property (ctrl_wr && pwdata[1:0] == 2'h3 |-> pslverr)
        else $error("output mode 3 accepted");
    run_lock_a: assert property (drive_running [*6] ##0 ctrl_wr |-> pslverr)
        else $error("control write accepted while running");
    code_unused_a: assert property (settled && mode_q == 2'h1 |->
        terminal_out[3:0] != 4'hB && terminal_out[3:0] != 4'hF)
        else $error("unused fault code on terminals");
    sep_fault_a: assert property (settled && mode_q == 2'h0 |->
        terminal_out[0] == $past(overcurrent_fault, 3))
        else $error("overcurrent terminal wrong in separate mode");
    sep_status_a: assert property (settled && mode_q == 2'h0 |->
        terminal_out[7:6] == {$past(speed_agree, 3), $past(zero_speed, 3)})
        else $error("status terminals wrong in separate mode");
    bin_status_a: assert property (settled && mode_q == 2'h1 |->
        terminal_out[7:4] == {$past(minor_fault, 3), $past(drive_running, 3),
        $past(speed_agree, 3), $past(zero_speed, 3)})
        else $error("status terminals wrong in binary mode");

    cover property (settled && mode_q == 2'h1 && terminal_out[3:0] != 4'h0);
    cover property (done && pslverr);
    cover property (settled && mode_q == 2'h2);
endmodule

bind fault_status_output_mapper fault_map_properties #(.ADDR_W(ADDR_W)) fault_map_properties_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .overcurrent_fault(overcurrent_fault), .zero_speed(zero_speed),
    .speed_agree(speed_agree), .drive_running(drive_running),
    .minor_fault(minor_fault), .terminal_out(terminal_out));

// ==== sim/tb_top.sv ====
// Self-checking bench of the fault/status output mapper.
// Drives APB, drive status and analog samples; judges terminals through the load model.
`timescale 1ns/1ps
module tb_top;
    import fault_map_pkg::*;
    localparam logic [63:0] sel_tab = 64'h1024_0201_1F13_0025;
    localparam logic [55:0] code_tab = 56'hED_C987_7A45_6321;
    localparam logic [11:0] rst_addr [4] = '{12'h000, 12'h004, 12'h008, 12'h014};
    localparam logic [31:0] rst_val [4] = '{32'h0000_0008, 32'h0402_0100,
        32'h0F0F_2506, 32'h0000_0000};
    localparam logic [5:0] cfg_tab [5] = '{6'h34, 6'h3C, 6'h38, 6'h18, 6'h08};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ref_ok, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [FI_COUNT-1:0] fi;
    logic [37:0] fn;
    logic [14:0] ch1, ch2, ch3, fref;
    logic [7:0] term, seen;
    logic [31:0] seed = 32'h3eee_0b0c;
    int miscompares = 0;
    int comparisons = 0;

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    fault_status_output_mapper fault_status_output_mapper_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .overcurrent_fault(fi[0]), .overvoltage_fault(fi[1]), .drive_overload_fault(fi[2]),
        .fuse_blown_fault(fi[3]), .overspeed_fault(fi[4]), .heatsink_overheat_fault(fi[5]),
        .motor_overload_fault(fi[6]), .braking_resistor_fault(fi[7]),
        .brake_transistor_fault(fi[8]), .external_fault(fi[9]), .controller_fault(fi[10]),
        .undervoltage_fault(fi[11]), .speed_deviation_fault(fi[12]),
        .encoder_open_fault(fi[13]), .zero_speed(fi[14]), .speed_agree(fi[15]),
        .drive_running(fi[16]), .minor_fault(fi[17]), .function_in(fn),
        .adc_ch1(ch1), .adc_ch2(ch2), .adc_ch3(ch3), .terminal_out(term),
        .frequency_ref(fref), .frequency_ref_valid(ref_ok), .irq(irq));

    terminal_load terminal_load_i (.pclk(pclk), .terminal_out(term), .contact_q(seen));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] sep(input logic [17:0] f);
        return {f[15], f[14], f[5] | f[6], f[4], f[3], f[2], f[1], f[0]};
    endfunction

    function automatic logic [3:0] low(input logic [17:0] f);
        logic [3:0] c;
        c = 4'h0;
        for (int j = 0; j < 14; j++) begin
            if (f[j] && (c == 4'h0 || code_tab[4*j +: 4] < c)) c = code_tab[4*j +: 4];
        end
        return c;
    endfunction

    function automatic logic [7:0] selx(input logic [37:0] f);
        logic [7:0] e;
        for (int k = 0; k < 8; k++) e[k] = f[sel_tab[8*k +: 6]];
        return e;
    endfunction

    // Saturated sum of the channels that the card setting combines
    function automatic logic [14:0] eref(input logic [5:0] c);
        int s;
        s = $signed(ch1);
        if (!c[3] || c[2]) s += $signed(ch2);
        if (c[3] && c[2]) s += $signed(ch3);
        if (s > 16383) s = 16383;
        if (s < -16384) s = -16384;
        return 15'(s);
    endfunction

    task automatic final_report();
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            miscompares++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Two sync stages, the output register and the load each take one edge
    task automatic setf(input logic [17:0] v);
        @(posedge pclk);
        fi <= v;
        repeat (5) @(posedge pclk);
    endtask

    initial begin
        logic [17:0] v;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fi = '0;
        fn = '0;
        ch1 = '0;
        ch2 = '0;
        ch3 = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, rst_addr[i], '0);
            chk("reset value", rd, rst_val[i]);
        end
        apb(1'b0, 12'h020, '0);
        chk("unmapped error", 32'(er), 32'h1);
        for (int i = 0; i < 12; i++) begin
            v = 18'(xs());
            setf(v);
            chk("separate terminals", 32'(seen), 32'(sep(v)));
        end
        setf('0);
        apb(1'b1, 12'h000, 32'h0000_0009);
        for (int i = 0; i < 14; i++) begin
            setf(18'h1 << i);
            chk("fault code", 32'(seen[3:0]), 32'(code_tab[4*i +: 4]));
            setf('0);
            chk("code cleared", 32'(seen[3:0]), 32'h0);
        end
        for (int i = 0; i < 10; i++) begin
            v = 18'(xs());
            setf(v);
            chk("binary terminals", 32'(seen), 32'({v[17:14], low(v)}));
            setf('0);
        end
        setf(18'h0_2000);
        setf(18'h0_2001);
        chk("code held", 32'(seen[3:0]), 32'hE);
        apb(1'b0, 12'h00C, '0);
        chk("status code", 32'(rd[11:8]), 32'hE);
        setf(18'h0_0001);
        chk("code next", 32'(seen[3:0]), 32'h1);
        setf('0);
        apb(1'b1, 12'h014, 32'h0000_0001);
        apb(1'b1, 12'h010, 32'h0000_0007);
        @(posedge pclk);
        chk("irq idle", 32'(irq), 32'h0);
        setf(18'h0_0001);
        chk("irq raised", 32'(irq), 32'h1);
        apb(1'b0, 12'h010, '0);
        chk("fault event", 32'(rd[0]), 32'h1);
        apb(1'b1, 12'h010, 32'h0000_0001);
        @(posedge pclk);
        chk("irq cleared", 32'(irq), 32'h0);
        setf('0);
        chk("irq masked", 32'(irq), 32'h0);
        apb(1'b0, 12'h010, '0);
        chk("clear event", 32'(rd[1:0]), 32'h2);
        apb(1'b1, 12'h000, 32'h0000_000B);
        chk("mode 3 refused", 32'(er), 32'h1);
        apb(1'b0, 12'h010, '0);
        chk("refused event", 32'(rd[2]), 32'h1);
        setf(18'h1_0000);
        apb(1'b1, 12'h000, 32'h0000_0008);
        chk("running lock", 32'(er), 32'h1);
        apb(1'b0, 12'h000, '0);
        chk("mode kept", rd, 32'h0000_0009);
        setf('0);
        apb(1'b1, 12'h004, sel_tab[31:0]);
        apb(1'b1, 12'h008, sel_tab[63:32]);
        apb(1'b1, 12'h000, 32'h0000_000A);
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            fn <= 38'({xs(), xs()});
            setf(18'(xs()) & 18'h0_FFFF);
            chk("selected terminals", 32'(seen), 32'(selx(fn)));
        end
        apb(1'b1, 12'h004, 32'h0000_0026);
        chk("selection refused", 32'(er), 32'h1);
        apb(1'b0, 12'h004, '0);
        chk("selection kept", rd, sel_tab[31:0]);
        setf('0);
        for (int i = 0; i < 5; i++) begin
            @(posedge pclk);
            ch1 <= 15'(xs());
            ch2 <= 15'(xs());
            ch3 <= 15'(xs());
            apb(1'b1, 12'h000, 32'(cfg_tab[i]));
            repeat (5) @(posedge pclk);
            chk("reference", 32'(fref), 32'(eref(cfg_tab[i])));
            chk("reference valid", 32'(ref_ok),
                32'(cfg_tab[i][5:4] == 2'h3 || cfg_tab[i][5:2] == 4'h6));
        end
        final_report();
    end
endmodule

// ==== sim/terminal_load.sv ====
// Equipment wired to the eight output terminals.
// Sees the contacts one clock late, as a slow external input would.
`timescale 1ns/1ps
module terminal_load (
    // Clock
    input wire logic pclk,
    // Terminals of the output card
    input wire logic [7:0] terminal_out,
    // Contact state as seen by the load
    output logic [7:0] contact_q
);
    always_ff @(posedge pclk) begin
        contact_q <= terminal_out;
    end
endmodule
